// ===== design/dsli_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dsli_map.svh"

module dsli_top
#(
	parameter dsli_pkg::dsli_res_t RES = dsli_pkg::DSLI_RES_12
)
(
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	input  wire logic                    ser_clk,
	input  wire logic                    serial_data_in,
	input  wire logic                    load_strobe_n,
	input  wire logic                    clear_to_zero_n,
	output logic      [`DSLI_CODE_W-1:0] dac_code_q,
	output logic                         load_pulse_q,
	output logic                         clear_active_q
);

	// ----------------------------------------------------------------
	// Variant width
	// ----------------------------------------------------------------
	function automatic int res_bits(input dsli_pkg::dsli_res_t r);
		if (r == dsli_pkg::DSLI_RES_10)
			return `DSLI_BITS_10;
		else
			return `DSLI_BITS_12;
	endfunction : res_bits

	localparam int NBITS = res_bits(RES);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic fell(input logic prev, input logic now);
		return prev & ~now;
	endfunction : fell

	function automatic logic rose(input logic prev, input logic now);
		return ~prev & now;
	endfunction : rose

	function automatic logic [`DSLI_CODE_W-1:0] fit_code(input logic [NBITS-1:0] w);
		logic [`DSLI_CODE_W-1:0] c;
		c = '0;
		c[NBITS-1:0] = w;
		return c;
	endfunction : fit_code

	// ----------------------------------------------------------------
	// Link reset
	// ----------------------------------------------------------------
	// Asserts with rst_n, releases on the second link clock edge after it
	logic link_rst_meta_q;
	logic link_rst_n_q;

	always_ff @(posedge ser_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_rst_meta_q <= 1'b0;
			link_rst_n_q    <= 1'b0;
		end
		else
		begin
			link_rst_meta_q <= 1'b1;
			link_rst_n_q    <= link_rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Shift register in the link domain
	// ----------------------------------------------------------------
	logic [NBITS-1:0] shift_word;

	dsli_shift
	#(
		.WIDTH (NBITS)
	)
	u_shift
	(
		.ser_clk        (ser_clk),
		.link_rst_n     (link_rst_n_q),
		.serial_data_in (serial_data_in),
		.load_strobe_n  (load_strobe_n),
		.shift_word_q   (shift_word)
	);

	// ----------------------------------------------------------------
	// Pin synchronisers into sys_clk
	// ----------------------------------------------------------------
	logic [1:0] pins_sync;
	wire  logic strobe_s;
	wire  logic clear_s;

	dsli_sync
	#(
		.W (2)
	)
	u_pin_sync
	(
		.clk      (sys_clk),
		.rst_n    (rst_n),
		.async_in ({load_strobe_n, clear_to_zero_n}),
		.sync_out (pins_sync)
	);

	assign strobe_s = pins_sync[1];
	assign clear_s  = pins_sync[0];

	// ----------------------------------------------------------------
	// Edge history
	// ----------------------------------------------------------------
	logic strobe_prev_q;
	logic clear_prev_q;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// Reset counts as a clear, so a high pin is seen as its release
			strobe_prev_q <= 1'b1;
			clear_prev_q  <= 1'b0;
		end
		else
		begin
			strobe_prev_q <= strobe_s;
			clear_prev_q  <= clear_s;
		end
	end

	// ----------------------------------------------------------------
	// Word capture
	// ----------------------------------------------------------------
	// The shift word is frozen while the strobe is low, so it is
	// stable by the time the synchronised strobe shows the fall.
	wire logic strobe_fall;
	wire logic clear_rise;
	wire logic clear_on;

	assign strobe_fall = fell(strobe_prev_q, strobe_s);
	assign clear_rise  = rose(clear_prev_q, clear_s);
	assign clear_on    = ~clear_s;

	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	dsli_pkg::dsli_state_t state_q;
	dsli_pkg::dsli_state_t state_d;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			dsli_pkg::DSLI_ST_RUN:
			begin
				if (clear_on)
					state_d = dsli_pkg::DSLI_ST_CLEAR;
			end
			dsli_pkg::DSLI_ST_CLEAR:
			begin
				if (clear_rise)
					state_d = dsli_pkg::DSLI_ST_RELEASE;
			end
			dsli_pkg::DSLI_ST_RELEASE:
			begin
				if (clear_on)
					state_d = dsli_pkg::DSLI_ST_CLEAR;
				else
					state_d = dsli_pkg::DSLI_ST_RUN;
			end
			default:
			begin
				state_d = dsli_pkg::DSLI_ST_CLEAR;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= dsli_pkg::DSLI_ST_CLEAR;
		else
			state_q <= state_d;
	end

	// ----------------------------------------------------------------
	// Transfer decision
	// ----------------------------------------------------------------
	wire logic in_run;
	wire logic release_load;
	wire logic do_load;
	wire logic do_zero;

	assign in_run       = (state_q == dsli_pkg::DSLI_ST_RUN);
	assign release_load = (state_q == dsli_pkg::DSLI_ST_RELEASE) & ~strobe_s;
	assign do_zero      = clear_on;
	assign do_load      = ~clear_on & ((in_run & strobe_fall) | release_load);

	// ----------------------------------------------------------------
	// DAC register
	// ----------------------------------------------------------------
	logic [`DSLI_CODE_W-1:0] dac_code_d;

	always_comb
	begin
		dac_code_d = dac_code_q;
		if (do_zero)
			dac_code_d = `DSLI_CODE_RST;
		else if (do_load)
			dac_code_d = fit_code(shift_word);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			dac_code_q <= `DSLI_CODE_RST;
		else
			dac_code_q <= dac_code_d;
	end

	// ----------------------------------------------------------------
	// Status outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			load_pulse_q   <= 1'b0;
			clear_active_q <= 1'b1;
		end
		else
		begin
			load_pulse_q   <= do_load;
			clear_active_q <= clear_on;
		end
	end

endmodule : dsli_top

`default_nettype wire

// ===== common/dsli_map.svh
`ifndef DSLI_MAP_SVH
`define DSLI_MAP_SVH

`define DSLI_CODE_W      12
`define DSLI_BITS_12     12
`define DSLI_BITS_10     10
`define DSLI_CODE_RST    12'h000
`define DSLI_SYNC_STAGES 2

`endif

// ===== common/dsli_pkg.sv
package dsli_pkg;

	typedef enum logic
	{
		DSLI_RES_12,
		DSLI_RES_10
	} dsli_res_t;

	typedef enum logic [1:0]
	{
		DSLI_ST_RUN,
		DSLI_ST_CLEAR,
		DSLI_ST_RELEASE
	} dsli_state_t;

endpackage : dsli_pkg

// ===== design/dsli_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "dsli_map.svh"

module dsli_sync
#(
	parameter int W = 1
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	// ----------------------------------------------------------------
	// Two flops, first one read only by the second
	// ----------------------------------------------------------------
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q   <= '1;
			sync_out <= '1;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : dsli_sync

`default_nettype wire

// ===== design/dsli_shift.sv
`timescale 1ns/10ps
`default_nettype none
`include "dsli_map.svh"

module dsli_shift
#(
	parameter int WIDTH = `DSLI_BITS_12
)
(
	input  wire logic             ser_clk,
	input  wire logic             link_rst_n,
	input  wire logic             serial_data_in,
	input  wire logic             load_strobe_n,
	output logic      [WIDTH-1:0] shift_word_q
);

	// ----------------------------------------------------------------
	// Shift register on the serial clock
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] shift_word_d;
	wire  logic       shift_en;

	assign shift_en     = load_strobe_n;
	assign shift_word_d = {shift_word_q[WIDTH-2:0], serial_data_in};

	always_ff @(posedge ser_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
			shift_word_q <= '0;
		else if (shift_en)
			shift_word_q <= shift_word_d;
	end

endmodule : dsli_shift

`default_nettype wire

// ===== test/dsli_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dsli_top_chk
#(
	parameter dsli_pkg::dsli_res_t RES = dsli_pkg::DSLI_RES_12
)
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        ser_clk,
	input wire logic        serial_data_in,
	input wire logic        load_strobe_n,
	input wire logic        clear_to_zero_n,
	input wire logic [11:0] dac_code_q,
	input wire logic        load_pulse_q,
	input wire logic        clear_active_q
);
	// ----
	// Checks
	// ----
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_clr_zero;
		(!clear_to_zero_n)[*5] |-> dac_code_q == 12'h000 && clear_active_q;
	endproperty
	a_clr_zero: assert property (p_clr_zero) else $error("code kept in clear");
	property p_clr_seen;
		$fell(clear_to_zero_n) |-> ##[1:5] clear_active_q;
	endproperty
	a_clr_seen: assert property (p_clr_seen) else $error("clear late");
	property p_clr_hold;
		clear_active_q && $past(clear_active_q) |-> dac_code_q == 12'h000 && !load_pulse_q;
	endproperty
	a_clr_hold: assert property (p_clr_hold) else $error("load in clear");
	property p_one_pulse;
		load_pulse_q |=> !load_pulse_q;
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("long pulse");
	property p_load;
		$fell(load_strobe_n) && clear_to_zero_n && !clear_active_q |-> ##[3:6] load_pulse_q;
	endproperty
	a_load: assert property (p_load) else $error("no transfer");
	property p_hold;
		$changed(dac_code_q) && !clear_active_q |-> load_pulse_q;
	endproperty
	a_hold: assert property (p_hold) else $error("code moved");
	property p_release;
		$rose(clear_to_zero_n) && !load_strobe_n |-> ##[3:7] load_pulse_q;
	endproperty
	a_release: assert property (p_release) else $error("no release load");
	property p_res10;
		RES == dsli_pkg::DSLI_RES_10 |-> dac_code_q[11:10] == 2'h0;
	endproperty
	a_res10: assert property (p_res10) else $error("top bits set");
	c_load: cover property (load_pulse_q);
	c_clear: cover property ($rose(clear_active_q));
	c_release: cover property ($rose(clear_to_zero_n) && !load_strobe_n);
endmodule : dsli_top_chk
bind dsli_top dsli_top_chk #(.RES(RES)) u_chk
(
	.sys_clk(sys_clk), .rst_n(rst_n), .ser_clk(ser_clk), .serial_data_in(serial_data_in),
	.load_strobe_n(load_strobe_n), .clear_to_zero_n(clear_to_zero_n),
	.dac_code_q(dac_code_q), .load_pulse_q(load_pulse_q), .clear_active_q(clear_active_q)
);
`default_nettype wire

// ===== test/dsli_host.sv
`timescale 1ns/10ps
`default_nettype none
module dsli_host
(
	output logic ser_clk,
	output logic serial_data_in,
	output logic load_strobe_n
);
	// ----
	// Host side
	// ----
	initial
	begin
		ser_clk = 1'b0;
		serial_data_in = 1'b0;
		load_strobe_n = 1'b1;
	end
	// Clock runs only in frames; data moves on the falling edge
	task send(input logic [15:0] w, input int n);
		#7;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_data_in = w[i];
			#24 ser_clk = 1'b1;
			#24 ser_clk = 1'b0;
		end
		serial_data_in = ~serial_data_in;
	endtask : send
	task strobe(input logic v);
		load_strobe_n <= v;
		#96;
	endtask : strobe
endmodule : dsli_host
`default_nettype wire

// ===== test/dsli_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dsli_top_tb_top;
	logic        sys_clk;
	logic        rst_n;
	logic        clear_to_zero_n;
	wire         ser_clk;
	wire         serial_data_in;
	wire         load_strobe_n;
	wire  [11:0] code12;
	wire  [11:0] code10;
	wire         clr12;
	wire         clr10;
	wire         pulse12;
	wire         pulse10;
	int          failures;
	int          checks_done;
	int          cycles;
	int          loads12 = 0;
	int          loads10 = 0;
	int          loads_want = 0;
	// ----
	// Parts
	// ----
	dsli_host host (.ser_clk(ser_clk), .serial_data_in(serial_data_in), .load_strobe_n(load_strobe_n));
	dsli_top #(.RES(dsli_pkg::DSLI_RES_12)) dut
	(
		.sys_clk(sys_clk), .rst_n(rst_n), .ser_clk(ser_clk), .serial_data_in(serial_data_in),
		.load_strobe_n(load_strobe_n), .clear_to_zero_n(clear_to_zero_n),
		.dac_code_q(code12), .load_pulse_q(pulse12), .clear_active_q(clr12)
	);
	dsli_top #(.RES(dsli_pkg::DSLI_RES_10)) dut_10
	(
		.sys_clk(sys_clk), .rst_n(rst_n), .ser_clk(ser_clk), .serial_data_in(serial_data_in),
		.load_strobe_n(load_strobe_n), .clear_to_zero_n(clear_to_zero_n),
		.dac_code_q(code10), .load_pulse_q(pulse10), .clear_active_q(clr10)
	);
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (pulse12 === 1'b1)
			loads12 <= loads12 + 1;
		if (pulse10 === 1'b1)
			loads10 <= loads10 + 1;
		if (cycles == 4000)
		begin
			failures++;
			stop_test();
		end
	end
	task chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task both(input logic [15:0] w);
		chk(code12, w[11:0]);
		chk(code10, {2'h0, w[9:0]});
	endtask : both
	task loads(input int n);
		loads_want += n;
		chk(loads12[11:0], loads_want[11:0]);
		chk(loads10[11:0], loads_want[11:0]);
	endtask : loads
	task t_load(input logic [15:0] old, input logic [15:0] w);
		host.send(w, 16);
		repeat (8) @(posedge sys_clk);
		both(old);
		loads(0);
		host.strobe(1'b0);
		repeat (8) @(posedge sys_clk);
		both(w);
		loads(1);
		host.strobe(1'b1);
	endtask : t_load
	task t_ignore(input logic [15:0] w);
		host.strobe(1'b0);
		host.send(16'h0000, 4);
		host.strobe(1'b1);
		host.strobe(1'b0);
		repeat (8) @(posedge sys_clk);
		both(w);
		loads(2);
		host.strobe(1'b1);
	endtask : t_ignore
	task t_clear(input logic [15:0] w);
		host.send(w, 16);
		@(posedge sys_clk) clear_to_zero_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk({10'h000, clr10, clr12}, 12'h003);
		both(16'h0000);
		host.strobe(1'b0);
		repeat (8) @(posedge sys_clk);
		both(16'h0000);
		loads(0);
		host.strobe(1'b1);
		@(posedge sys_clk) clear_to_zero_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		both(16'h0000);
		loads(0);
		chk({10'h000, clr10, clr12}, 12'h000);
		@(posedge sys_clk) clear_to_zero_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		host.strobe(1'b0);
		@(posedge sys_clk) clear_to_zero_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		both(w);
		loads(1);
		host.strobe(1'b1);
	endtask : t_clear
	task stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	initial
	begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		clear_to_zero_n = 1'b1;
		failures = 0;
		checks_done = 0;
		cycles = 0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		both(16'h0000);
		loads(0);
		t_load(16'h0000, 16'ha5c3);
		t_load(16'ha5c3, 16'h5a3c);
		t_load(16'h5a3c, 16'hffff);
		t_ignore(16'hffff);
		t_clear(16'h0bcd);
		stop_test();
	end
endmodule : dsli_top_tb_top
`default_nettype wire
